// >>> design/sfbwg_pkg.sv
// Purpose: Shared constants for the serial flash front end and write guard
// Assumes: Status word bit 0 is the busy flag, bit 15 the suspend flag
// Notes: Instruction codes not printed alongside the lane modes follow common practice
package sfbwg_pkg;
  // Instruction codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE = 8'hD8;
  localparam logic [7:0] OP_CE = 8'hC7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_SECE = 8'h44;
  localparam logic [7:0] OP_SECP = 8'h42;
  localparam logic [7:0] OP_PD = 8'hB9;
  localparam logic [7:0] OP_RPD = 8'hAB;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESM = 8'h7A;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_DOUT = 8'h3B;
  localparam logic [7:0] OP_DIO = 8'hBB;
  localparam logic [7:0] OP_QOUT = 8'h6B;
  localparam logic [7:0] OP_QIO = 8'hEB;
  localparam logic [7:0] OP_WQIO = 8'hE7;
  localparam logic [7:0] OP_OQIO = 8'hE3;
  // Status word bit positions
  localparam int BUSY_BIT = 0;
  localparam int WE_BIT = 1;
  localparam int BP_LO_BIT = 2;
  localparam int TB_BIT = 5;
  localparam int LOCK_LO_BIT = 7;
  localparam int LOCK_HI_BIT = 8;
  localparam int QUAD_BIT = 9;
  localparam int SUS_BIT = 15;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] STAT_WR_MASK = 16'h7BFC;
  localparam logic [15:0] STAT_OTP_MASK = 16'h3800;
  // Clock counts of address and dummy phases
  localparam logic [5:0] ADDR_CLK_X1 = 6'h18;
  localparam logic [5:0] ADDR_CLK_X2 = 6'h0C;
  localparam logic [5:0] ADDR_CLK_X4 = 6'h06;
  localparam logic [5:0] DUMMY_FAST = 6'h08;
  localparam logic [5:0] DUMMY_DIO = 6'h04;
  localparam logic [5:0] DUMMY_QIO = 6'h06;
  localparam logic [5:0] DUMMY_WQIO = 6'h04;
  localparam logic [5:0] DUMMY_OQIO = 6'h02;
  // Frame states
  typedef enum logic [5:0] {
    ST_CMD = 6'h01,
    ST_ADDR = 6'h02,
    ST_DUMMY = 6'h04,
    ST_DIN = 6'h08,
    ST_DOUT = 6'h10,
    ST_IGNORE = 6'h20
  } sfbwg_state_t;
endpackage

// >>> design/sfbwg_top.sv
// Purpose: Serial bus front end of a serial flash with write guarding
// Assumes: Array read data arrives on core_clk_i for the address shown
// Notes: All bus input pins pass two flops; the bus clock is sampled, not used as a clock
`timescale 1ns/1ps

// Overview of operation
// RL1: Single lane: sample instruction, address and data on bus clock rising edge.
// RL2: Single lane: shift read and status bits out on bus clock falling edge.
// RL3: Bus modes 0 and 3 both work; idle clock level is irrelevant.
// RL4: Opcodes 3Bh and BBh use lanes zero and one as two-way lanes.
// RL5: Four-lane reads use all lanes; protect pin is lane two, pause lane three.
// RL6: Four-lane instructions only honoured while quad enable is set.
// RL7: Pause works only in one and two lane operation while selected.
// RL8: Pause starts at pause edge if clock low, else after next falling edge.
// RL9: Pause ends at pause edge if clock low, else after next falling edge.
// RL10: Paused: output floats, input and clock ignored, frame state kept.
// RL11: Master keeps select low during pause; raising it resets the frame.
// RL12: Write-type instructions rejected until power-up inhibit delay expires.
// RL13: Latch clear at power-up; writes need a prior write enable.
// RL14: Program, erase or status write completion clears the latch.
// RL15: In power-down only the release instruction is honoured.
// RL16: Status writes gated by lock bits, latch, and protect pin outside quad.
// RL17: Busy bit set during operations; only status read and suspend honoured.
// RL18: Operation end clears busy and instructions are accepted again.
// RL19: Latch is status bit one, set by write enable.
// RL20: Write disable clears the latch; other write-type instructions clear it only on completion.
// RL21: Three protect bits at status two to four, set by status write.
// RL22: Protect bits reset to zero, nothing protected.
// RL23: Lock bits 00: protect pin ignored, latch alone gates status writes.
// RL24: Lock bits 01 with protect pin low: status register locked.
// RL25: Quad enable is status bit nine and disables protect and pause pins.
// RL26: Select high abandons partial instruction; next frame starts fresh.
module sfbwg_top #(
  parameter int CNT_W = 24,
  parameter logic [CNT_W-1:0] INHIBIT_CYCLES = 24'h0003E8,
  parameter logic [CNT_W-1:0] PROG_CYCLES = 24'h0003E8,
  parameter logic [CNT_W-1:0] ERASE_CYCLES = 24'h0007D0,
  parameter logic [CNT_W-1:0] WRSR_CYCLES = 24'h0003E8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Bus clock and select from the master
  input wire logic sclk_i,
  input wire logic cs_n_i,
  // Data lanes, each input, output and active-low enable
  input wire logic lane_zero_i,
  output logic lane_zero_o,
  output logic lane_zero_oe_n_o,
  input wire logic lane_one_i,
  output logic lane_one_o,
  output logic lane_one_oe_n_o,
  input wire logic lane_two_i,
  output logic lane_two_o,
  output logic lane_two_oe_n_o,
  input wire logic lane_three_i,
  output logic lane_three_o,
  output logic lane_three_oe_n_o,
  // Array read port
  output logic [23:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic sclk_q;
    logic cs_q;
    sfbwg_pkg::sfbwg_state_t st;
    logic [5:0] cnt;
    logic [5:0] alen;
    logic [5:0] dumm;
    logic din;
    logic [7:0] opc;
    logic [31:0] sh;
    logic [5:0] dbits;
    logic [2:0] win;
    logic [2:0] wout;
    logic quad;
    logic paused;
    logic [7:0] osr;
    logic [3:0] ocnt;
    logic odrv;
    logic [3:0] obits;
    logic [23:0] addr;
    logic [15:0] stat;
    logic pd;
    logic [CNT_W-1:0] bcnt;
    logic [CNT_W-1:0] pucnt;
  } sfbwg_regs_t;

  sfbwg_regs_t r;
  sfbwg_regs_t n;
  logic cs_n;
  logic sclk;
  logic rise;
  logic fall;
  logic qen;
  logic lock;
  logic wr_ok;
  logic prot;
  logic [31:0] sh_new;
  logic [7:0] obyte;
  logic [7:0] src;
  logic [5:0] psize;
  logic [2:0] bp;
  logic drive;

  // Synchronised pin views and bus clock edges
  assign cs_n = r.sync2[5];
  assign sclk = r.sync2[4];
  assign rise = sclk & ~r.sclk_q; // RL3
  assign fall = ~sclk & r.sclk_q; // RL3
  assign qen = r.stat[sfbwg_pkg::QUAD_BIT];
  assign bp = r.stat[sfbwg_pkg::BP_LO_BIT +: 3];

  // Status lock: protect pin only counts outside quad mode
  assign lock = r.stat[sfbwg_pkg::LOCK_HI_BIT] | // RL16
    (r.stat[sfbwg_pkg::LOCK_LO_BIT] & ~r.sync2[2] & ~qen); // RL23 RL24 RL25
  assign wr_ok = r.stat[sfbwg_pkg::WE_BIT] & (r.pucnt == '0) & // RL12 RL13
    ~r.stat[sfbwg_pkg::BUSY_BIT] & ~r.pd;

  // Protected region in 64KB blocks, top or bottom; sector and complement ignored
  assign psize = (bp == 3'h0) ? 6'h00 : 6'(6'h01 << (bp - 3'h1));
  assign prot = (bp >= 3'h6) ? 1'b1 : // RL21
    (r.stat[sfbwg_pkg::TB_BIT] ? ({1'b0, r.addr[20:16]} < psize) :
    (psize != 6'h00) && ({1'b0, r.addr[20:16]} >= 6'h20 - psize));

  // Input shift by lane width
  always_comb begin
    case (r.win)
      3'h2: sh_new = {r.sh[29:0], r.sync2[1:0]}; // RL4
      3'h4: sh_new = {r.sh[27:0], r.sync2[3:0]}; // RL5
      default: sh_new = {r.sh[30:0], r.sync2[0]}; // RL1
    endcase
  end

  // Output byte source
  always_comb begin
    if (r.opc == sfbwg_pkg::OP_RDSR1) begin
      src = r.stat[7:0];
    end else if (r.opc == sfbwg_pkg::OP_RDSR2) begin
      src = r.stat[15:8];
    end else begin
      src = rd_data_i;
    end
    obyte = (r.ocnt == 4'h0) ? src : r.osr;
  end

  // Next state
  always_comb begin
    n = r;
    n.sync1 = {cs_n_i, sclk_i, lane_three_i, lane_two_i, lane_one_i, lane_zero_i};
    n.sync2 = r.sync1;
    n.sclk_q = sclk;
    n.cs_q = cs_n;
    // Power-up write inhibit countdown
    if (r.pucnt != '0) begin
      n.pucnt = r.pucnt - 1'b1;
    end
    // Operation timer freezes while suspended
    if (r.bcnt != '0 && !r.stat[sfbwg_pkg::SUS_BIT]) begin
      n.bcnt = r.bcnt - 1'b1;
      if (r.bcnt == CNT_W'(1)) begin
        n.stat[sfbwg_pkg::BUSY_BIT] = 1'b0; // RL18
        n.stat[sfbwg_pkg::WE_BIT] = 1'b0; // RL14
      end
    end
    // Pause follows the pin only while the bus clock is low
    if (cs_n) begin
      n.paused = 1'b0; // RL11
    end else if (!qen && !r.quad && !sclk) begin // RL7 RL25
      n.paused = ~r.sync2[3]; // RL8 RL9
    end
    if (cs_n) begin
      // Frame end: act on a complete instruction, then start over
      if (!r.cs_q && r.st == sfbwg_pkg::ST_DIN) begin
        case (r.opc)
          sfbwg_pkg::OP_WREN: begin
            if (r.dbits == 6'h00 && r.pucnt == '0) begin // RL12
              n.stat[sfbwg_pkg::WE_BIT] = 1'b1; // RL19
            end
          end
          sfbwg_pkg::OP_WRDI: begin
            if (r.dbits == 6'h00) begin
              n.stat[sfbwg_pkg::WE_BIT] = 1'b0; // RL20
            end
          end
          sfbwg_pkg::OP_WRSR: begin
            if ((r.dbits == 6'h08 || r.dbits == 6'h10) && wr_ok && !lock) begin // RL16
              n.stat = (r.stat & ~sfbwg_pkg::STAT_WR_MASK) | // RL21
                (r.stat & sfbwg_pkg::STAT_OTP_MASK) |
                (((r.dbits == 6'h08) ? {r.stat[15:8], r.sh[7:0]} :
                {r.sh[7:0], r.sh[15:8]}) & sfbwg_pkg::STAT_WR_MASK);
              n.stat[sfbwg_pkg::BUSY_BIT] = 1'b1; // RL17
              n.stat[sfbwg_pkg::WE_BIT] = 1'b1;
              n.bcnt = WRSR_CYCLES;
            end
          end
          sfbwg_pkg::OP_PP, sfbwg_pkg::OP_QPP: begin
            if (r.dbits >= 6'h08 && wr_ok && !prot) begin // RL13
              n.stat[sfbwg_pkg::BUSY_BIT] = 1'b1; // RL17
              n.bcnt = PROG_CYCLES;
            end
          end
          sfbwg_pkg::OP_SE, sfbwg_pkg::OP_BE32, sfbwg_pkg::OP_BE: begin
            if (r.dbits == 6'h00 && wr_ok && !prot) begin // RL13
              n.stat[sfbwg_pkg::BUSY_BIT] = 1'b1; // RL17
              n.bcnt = ERASE_CYCLES;
            end
          end
          sfbwg_pkg::OP_CE, sfbwg_pkg::OP_CE2: begin
            if (r.dbits == 6'h00 && wr_ok && bp == 3'h0) begin // RL13
              n.stat[sfbwg_pkg::BUSY_BIT] = 1'b1; // RL17
              n.bcnt = ERASE_CYCLES;
            end
          end
          sfbwg_pkg::OP_SECE, sfbwg_pkg::OP_SECP: begin
            if (wr_ok) begin
              n.stat[sfbwg_pkg::BUSY_BIT] = 1'b1; // RL17
              n.bcnt = PROG_CYCLES;
            end
          end
          sfbwg_pkg::OP_PD: begin
            if (r.dbits == 6'h00) begin
              n.pd = 1'b1;
            end
          end
          sfbwg_pkg::OP_RPD: begin
            n.pd = 1'b0; // RL15
          end
          sfbwg_pkg::OP_SUSP: begin
            if (r.stat[sfbwg_pkg::BUSY_BIT]) begin
              n.stat[sfbwg_pkg::SUS_BIT] = 1'b1;
              n.stat[sfbwg_pkg::BUSY_BIT] = 1'b0;
            end
          end
          sfbwg_pkg::OP_RESM: begin
            if (r.stat[sfbwg_pkg::SUS_BIT]) begin
              n.stat[sfbwg_pkg::SUS_BIT] = 1'b0;
              n.stat[sfbwg_pkg::BUSY_BIT] = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      // Partial frames are dropped here
      n.st = sfbwg_pkg::ST_CMD; // RL26
      n.cnt = 6'h00;
      n.dbits = 6'h00;
      n.win = 3'h1;
      n.wout = 3'h1;
      n.quad = 1'b0;
      n.din = 1'b0;
      n.dumm = 6'h00;
      n.ocnt = 4'h0;
      n.odrv = 1'b0;
    end else if (!r.paused) begin // RL10
      if (rise) begin
        n.sh = sh_new;
        n.cnt = r.cnt + 6'h01;
        case (r.st)
          sfbwg_pkg::ST_CMD: begin
            if (r.cnt == 6'h07) begin
              n.opc = sh_new[7:0];
              n.cnt = 6'h00;
              n.st = sfbwg_pkg::ST_IGNORE;
              n.alen = sfbwg_pkg::ADDR_CLK_X1;
              if (r.pd) begin
                if (sh_new[7:0] == sfbwg_pkg::OP_RPD) begin // RL15
                  n.st = sfbwg_pkg::ST_DIN;
                end
              end else if (r.stat[sfbwg_pkg::BUSY_BIT]) begin
                if (sh_new[7:0] == sfbwg_pkg::OP_RDSR1 || sh_new[7:0] == sfbwg_pkg::OP_RDSR2) begin
                  n.st = sfbwg_pkg::ST_DOUT; // RL17
                end else if (sh_new[7:0] == sfbwg_pkg::OP_SUSP) begin
                  n.st = sfbwg_pkg::ST_DIN; // RL17
                end
              end else begin
                case (sh_new[7:0])
                  sfbwg_pkg::OP_RDSR1, sfbwg_pkg::OP_RDSR2: begin
                    n.st = sfbwg_pkg::ST_DOUT;
                  end
                  sfbwg_pkg::OP_READ: begin
                    n.st = sfbwg_pkg::ST_ADDR;
                  end
                  sfbwg_pkg::OP_FREAD: begin
                    n.st = sfbwg_pkg::ST_ADDR;
                    n.dumm = sfbwg_pkg::DUMMY_FAST;
                  end
                  sfbwg_pkg::OP_DOUT: begin
                    n.st = sfbwg_pkg::ST_ADDR; // RL4
                    n.dumm = sfbwg_pkg::DUMMY_FAST;
                    n.wout = 3'h2;
                  end
                  sfbwg_pkg::OP_DIO: begin
                    n.st = sfbwg_pkg::ST_ADDR; // RL4
                    n.alen = sfbwg_pkg::ADDR_CLK_X2;
                    n.dumm = sfbwg_pkg::DUMMY_DIO;
                    n.win = 3'h2;
                    n.wout = 3'h2;
                  end
                  sfbwg_pkg::OP_QOUT: begin
                    if (qen) begin // RL6
                      n.st = sfbwg_pkg::ST_ADDR; // RL5
                      n.dumm = sfbwg_pkg::DUMMY_FAST;
                      n.wout = 3'h4;
                      n.quad = 1'b1;
                    end
                  end
                  sfbwg_pkg::OP_QIO, sfbwg_pkg::OP_WQIO, sfbwg_pkg::OP_OQIO: begin
                    if (qen) begin // RL6
                      n.st = sfbwg_pkg::ST_ADDR; // RL5
                      n.alen = sfbwg_pkg::ADDR_CLK_X4;
                      n.dumm = (sh_new[7:0] == sfbwg_pkg::OP_QIO) ? sfbwg_pkg::DUMMY_QIO :
                        (sh_new[7:0] == sfbwg_pkg::OP_WQIO) ? sfbwg_pkg::DUMMY_WQIO :
                        sfbwg_pkg::DUMMY_OQIO;
                      n.win = 3'h4;
                      n.wout = 3'h4;
                      n.quad = 1'b1;
                    end
                  end
                  sfbwg_pkg::OP_QPP: begin
                    if (qen) begin // RL6
                      n.st = sfbwg_pkg::ST_ADDR;
                      n.din = 1'b1;
                      n.quad = 1'b1;
                    end
                  end
                  sfbwg_pkg::OP_PP, sfbwg_pkg::OP_SE, sfbwg_pkg::OP_BE32, sfbwg_pkg::OP_BE,
                  sfbwg_pkg::OP_SECE, sfbwg_pkg::OP_SECP: begin
                    n.st = sfbwg_pkg::ST_ADDR;
                    n.din = 1'b1;
                  end
                  default: begin
                    n.st = sfbwg_pkg::ST_DIN;
                  end
                endcase
              end
            end
          end
          sfbwg_pkg::ST_ADDR: begin
            if (r.cnt + 6'h01 == r.alen) begin
              n.addr = sh_new[23:0];
              n.cnt = 6'h00;
              n.win = (r.opc == sfbwg_pkg::OP_QPP) ? 3'h4 : 3'h1;
              if (r.din) begin
                n.st = sfbwg_pkg::ST_DIN;
              end else if (r.dumm != 6'h00) begin
                n.st = sfbwg_pkg::ST_DUMMY;
              end else begin
                n.st = sfbwg_pkg::ST_DOUT;
              end
            end
          end
          sfbwg_pkg::ST_DUMMY: begin
            if (r.cnt + 6'h01 == r.dumm) begin
              n.st = sfbwg_pkg::ST_DOUT;
            end
          end
          sfbwg_pkg::ST_DIN: begin
            if (r.dbits < 6'h38) begin
              n.dbits = r.dbits + {3'h0, r.win};
            end
          end
          default: begin
          end
        endcase
      end
      // Output shifting on the falling edge; array address moves per byte
      if (fall && r.st == sfbwg_pkg::ST_DOUT) begin
        n.odrv = 1'b1;
        case (r.wout)
          3'h2: n.obits = {2'h0, obyte[7:6]}; // RL4
          3'h4: n.obits = obyte[7:4]; // RL5
          default: n.obits = {2'h0, obyte[7], 1'b0}; // RL2
        endcase
        n.osr = 8'(obyte << r.wout);
        n.ocnt = ((r.ocnt == 4'h0) ? 4'h8 : r.ocnt) - {1'b0, r.wout};
        if (r.ocnt == 4'h0) begin
          n.addr = r.addr + 24'h000001;
        end
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.sync1 <= 6'h3F;
      r.sync2 <= 6'h3F;
      r.cs_q <= 1'b1;
      r.st <= sfbwg_pkg::ST_CMD;
      r.win <= 3'h1;
      r.wout <= 3'h1;
      r.stat <= sfbwg_pkg::STAT_RST; // RL13 RL22
      r.pucnt <= INHIBIT_CYCLES; // RL12
    end else begin
      r <= n;
    end
  end

  // Lane drivers; float whenever deselected or paused
  assign drive = r.odrv && (r.st == sfbwg_pkg::ST_DOUT) && !cs_n && !r.paused; // RL10
  assign lane_zero_o = r.obits[0];
  assign lane_one_o = r.obits[1];
  assign lane_two_o = r.obits[2];
  assign lane_three_o = r.obits[3];
  assign lane_zero_oe_n_o = ~(drive && r.wout != 3'h1);
  assign lane_one_oe_n_o = ~drive;
  assign lane_two_oe_n_o = ~(drive && r.wout == 3'h4);
  assign lane_three_oe_n_o = ~(drive && r.wout == 3'h4);
  assign rd_addr_o = r.addr;

endmodule

// >>> test/sfbwg_master.sv
// Purpose: Bus master model that drives whole frames into the flash front end
// Assumes: Lanes with no driver are pulled up in the bench
// Notes: Half bus period is ten core clocks; every change lands on a falling core edge
`timescale 1ns/1ps
module sfbwg_master (
  // Pacing clock
  input wire logic clk_i,
  // Resolved lanes
  input wire logic lane0_i,
  input wire logic lane1_i,
  // Bus pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic d0_o,
  output logic d0_en_o,
  output logic wp_n_o,
  output logic hold_n_o
);
  // Deselected, mode 0 idle
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    d0_o = 1'b0;
    d0_en_o = 1'b0;
    wp_n_o = 1'b1;
    hold_n_o = 1'b1;
  end
  // Half a bus period, 80 ns
  task automatic half;
    repeat (10) @(negedge clk_i);
  endtask
  // Falling clock edge, then wait
  task automatic tick_low;
    sclk_o = 1'b0;
    half();
  endtask
  // Idle level settles before select falls, so no clock edge at select
  task automatic sel(input bit m3);
    sclk_o = m3;
    half();
    cs_n_o = 1'b0;
    d0_en_o = 1'b1;
    half();
  endtask
  // Bits out MSB first, data set while the clock is low
  task automatic put(input logic [39:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      d0_o = v[i];
      half();
      sclk_o = 1'b1;
      half();
    end
  endtask
  // Read bits at each rising edge; lane zero released for two-lane data
  task automatic get(input int n, input bit dual, output logic [15:0] v);
    v = 16'h0000;
    d0_en_o = !dual;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      half();
      sclk_o = 1'b1;
      v = dual ? {v[13:0], lane1_i, lane0_i} : {v[14:0], lane1_i};
      half();
    end
  endtask
  // Mode 0 returns the clock low before select rises
  task automatic desel(input bit m3);
    if (!m3) begin
      tick_low();
    end
    cs_n_o = 1'b1;
    d0_en_o = 1'b0;
    half();
  endtask
  // One complete single-lane frame
  task automatic frame(input bit m3, input logic [39:0] v, input int n, input int rn,
                       output logic [15:0] r);
    r = 16'h0000;
    sel(m3);
    put(v, n);
    if (rn > 0) begin
      get(rn, 1'b0, r);
    end
    desel(m3);
  endtask
  // Protect and pause levels; pause only moves while selected
  task automatic pins(input logic wp, input logic hold);
    wp_n_o = wp;
    hold_n_o = hold;
  endtask
endmodule

// >>> test/sfbwg_top_sva.sv
// Purpose: Port-level assertions for the flash front end
// Assumes: Bus half period well above the three-clock sync delay
// Notes: Raw pin edges lead what the design sees by about three clocks
`timescale 1ns/1ps
module sfbwg_sva_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Bus pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic lane_three_i,
  // Lane outputs
  input wire logic lane_zero_o,
  input wire logic lane_one_o,
  input wire logic lane_zero_oe_n_o,
  input wire logic lane_one_oe_n_o,
  input wire logic lane_two_oe_n_o,
  input wire logic lane_three_oe_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] rise_cnt;
  // Bus clock rises since select fell, saturating at one opcode
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_cnt <= 4'h0;
    end else if (cs_n_i) begin
      rise_cnt <= 4'h0;
    end else if ($rose(sclk_i) && rise_cnt < 4'h8) begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end
  chk_sel_float: assert property (cs_n_i [*4] |-> lane_zero_oe_n_o && lane_one_oe_n_o
    && lane_two_oe_n_o && lane_three_oe_n_o) else $error("lanes driven while deselected");
  chk_cmd_input: assert property (!cs_n_i && !$past(cs_n_i, 4) && rise_cnt < 4'h8
    |-> lane_zero_oe_n_o && lane_one_oe_n_o) else $error("lane driven during opcode");
  chk_out_fall: assert property (!lane_one_oe_n_o && !$past(lane_one_oe_n_o)
    && $changed(lane_one_o) |-> !sclk_i && !$past(sclk_i, 3)) else $error("bit not on fall");
  chk_dual_fall: assert property (!lane_zero_oe_n_o && !$past(lane_zero_oe_n_o)
    && $changed(lane_zero_o) |-> !sclk_i && !$past(sclk_i, 3)) else $error("lane zero off fall");
  chk_dual_pair: assert property (!lane_zero_oe_n_o |-> !lane_one_oe_n_o)
    else $error("lane zero driven alone");
  chk_quad_group: assert property (!lane_two_oe_n_o |-> !lane_three_oe_n_o
    && !lane_zero_oe_n_o && !lane_one_oe_n_o) else $error("partial quad drive");
  chk_pause_float: assert property ((!cs_n_i && !lane_three_i && !sclk_i
    && lane_two_oe_n_o) [*6] |-> lane_one_oe_n_o && lane_zero_oe_n_o) else $error("driven in pause");
  chk_pause_start: assert property ($fell(lane_three_i) && !sclk_i && !cs_n_i
    && lane_two_oe_n_o |-> ##[1:6] lane_one_oe_n_o) else $error("pause did not start");
endmodule
bind sfbwg_top sfbwg_sva_chk u_sfbwg_sva_chk (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .sclk_i(sclk_i),
  .cs_n_i(cs_n_i),
  .lane_three_i(lane_three_i),
  .lane_zero_o(lane_zero_o),
  .lane_one_o(lane_one_o),
  .lane_zero_oe_n_o(lane_zero_oe_n_o),
  .lane_one_oe_n_o(lane_one_oe_n_o),
  .lane_two_oe_n_o(lane_two_oe_n_o),
  .lane_three_oe_n_o(lane_three_oe_n_o)
);

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the flash front end and write guard
// Assumes: Short inhibit and busy counts set at the instance
// Notes: Array byte is its address low byte XOR 5Ah
`timescale 1ns/1ps
module tb_top;
  // Clock, reset and counters
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  // Bus pins, lanes and array port
  logic sclk, cs_n, d0, d0_en, wp_n, hold_n, l0, l1, l2, l3;
  logic l0_o, l1_o, l2_o, l3_o, l0_oe_n, l1_oe_n, l2_oe_n, l3_oe_n;
  logic [23:0] rd_addr;
  logic [7:0] rd_data;
  logic [15:0] r;

  always #4 core_clk_i = ~core_clk_i;
  // Predictable array content
  assign rd_data = rd_addr[7:0] ^ 8'h5A;
  // Pull-ups on lanes zero and one; protect and pause pins drive lanes two and three when not data
  assign l0 = !l0_oe_n ? l0_o : (d0_en ? d0 : 1'b1);
  assign l1 = !l1_oe_n ? l1_o : 1'b1;
  assign l2 = !l2_oe_n ? l2_o : wp_n;
  assign l3 = !l3_oe_n ? l3_o : hold_n;

  sfbwg_top #(.INHIBIT_CYCLES(24'h00012C), .PROG_CYCLES(24'h000010),
    .ERASE_CYCLES(24'h000010), .WRSR_CYCLES(24'h000258)) u_sfbwg_top (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .lane_zero_i(l0), .lane_zero_o(l0_o), .lane_zero_oe_n_o(l0_oe_n),
    .lane_one_i(l1), .lane_one_o(l1_o), .lane_one_oe_n_o(l1_oe_n),
    .lane_two_i(l2), .lane_two_o(l2_o), .lane_two_oe_n_o(l2_oe_n),
    .lane_three_i(l3), .lane_three_o(l3_o), .lane_three_oe_n_o(l3_oe_n),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data));
  sfbwg_master u_sfbwg_master (.clk_i(core_clk_i), .lane0_i(l0), .lane1_i(l1), .sclk_o(sclk),
    .cs_n_o(cs_n), .d0_o(d0), .d0_en_o(d0_en), .wp_n_o(wp_n), .hold_n_o(hold_n));

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Frame helpers
  task automatic wr(input logic [39:0] v, input int n);
    u_sfbwg_master.frame(1'b0, v, n, 0, r);
  endtask
  task automatic rdsr(input bit m3, output logic [15:0] s);
    u_sfbwg_master.frame(m3, 40'h05, 8, 8, s);
  endtask
  // Bounded busy poll; a stuck flag ends the run
  task automatic poll(output logic [15:0] s);
    for (int k = 0; k < 20; k++) begin
      rdsr(1'b0, s);
      if (s[0] === 1'b0) return;
    end
    miscompares++;
    $display("unexpected at %0t: busy stuck", $time);
    stop_test();
  endtask

  task automatic t_inhibit;
    wr(40'h06, 8);
    rdsr(1'b0, r);
    chk(r, 16'h0000);
    u_sfbwg_master.frame(1'b1, 40'h06, 8, 0, r);
    rdsr(1'b1, r);
    chk(r, 16'h0002);
    $display("inhibit test done");
  endtask
  // Latch still set from the previous test
  task automatic t_busy;
    wr(40'h011C, 16);
    wr(40'h04, 8);
    rdsr(1'b0, r);
    chk(r, 16'h001F);
    poll(r);
    chk(r, 16'h001C);
    $display("busy test done");
  endtask
  // Pause mid status read, clock toggled while paused
  task automatic t_pause;
    logic [2:0] a;
    u_sfbwg_master.sel(1'b0);
    u_sfbwg_master.put(40'h05, 8);
    u_sfbwg_master.get(3, 1'b0, r);
    a = r[2:0];
    u_sfbwg_master.tick_low();
    u_sfbwg_master.pins(1'b1, 1'b0);
    u_sfbwg_master.half();
    chk({15'h0000, l1_oe_n}, 16'h0001);
    u_sfbwg_master.put(40'h03, 2);
    u_sfbwg_master.tick_low();
    u_sfbwg_master.pins(1'b1, 1'b1);
    u_sfbwg_master.half();
    u_sfbwg_master.get(5, 1'b0, r);
    u_sfbwg_master.desel(1'b0);
    chk({8'h00, a, r[4:0]}, 16'h001C);
    $display("pause test done");
  endtask
  task automatic t_wrdi;
    wr(40'h06, 8);
    rdsr(1'b0, r);
    chk(r, 16'h001E);
    wr(40'h04, 8);
    rdsr(1'b0, r);
    chk(r, 16'h001C);
    wr(40'hB9, 8);
    wr(40'h06, 8);
    wr(40'hAB, 8);
    rdsr(1'b0, r);
    chk(r, 16'h001C);
    u_sfbwg_master.sel(1'b0);
    u_sfbwg_master.put(40'h00, 4);
    u_sfbwg_master.desel(1'b0);
    rdsr(1'b0, r);
    chk(r, 16'h001C);
    $display("latch test done");
  endtask
  // Protect pin low throughout the first two writes
  task automatic t_lock;
    u_sfbwg_master.pins(1'b0, 1'b1);
    wr(40'h06, 8);
    wr(40'h0180, 16);
    poll(r);
    chk(r, 16'h0080);
    wr(40'h06, 8);
    wr(40'h0184, 16);
    rdsr(1'b0, r);
    chk(r, 16'h0082);
    u_sfbwg_master.pins(1'b1, 1'b1);
    wr(40'h0100, 16);
    poll(r);
    chk(r, 16'h0000);
    wr(40'h0104, 16);
    rdsr(1'b0, r);
    chk(r, 16'h0000);
    $display("lock test done");
  endtask
  // Two-lane read, then a four-lane read refused while quad is off
  task automatic t_dual;
    u_sfbwg_master.sel(1'b0);
    u_sfbwg_master.put(40'h3B000010, 32);
    u_sfbwg_master.put(40'h00, 8);
    u_sfbwg_master.get(8, 1'b1, r);
    u_sfbwg_master.desel(1'b0);
    chk(r, 16'h4A4B);
    u_sfbwg_master.frame(1'b0, 40'h6B00001000, 40, 8, r);
    chk(r, 16'h00FF);
    $display("lane test done");
  endtask
  // Quad enable on, then a four-lane read
  task automatic t_quad;
    wr(40'h06, 8);
    wr(40'h010002, 24);
    poll(r);
    chk(r, 16'h0000);
    u_sfbwg_master.sel(1'b0);
    u_sfbwg_master.put(40'h6B00001000, 40);
    u_sfbwg_master.get(1, 1'b1, r);
    chk({12'h000, l3, l2, r[1:0]}, 16'h0004);
    u_sfbwg_master.get(1, 1'b1, r);
    chk({12'h000, l3, l2, r[1:0]}, 16'h000A);
    u_sfbwg_master.desel(1'b0);
    $display("quad test done");
  endtask

  // Main sequence
  initial begin
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_inhibit();
    t_busy();
    t_pause();
    t_wrdi();
    t_lock();
    t_dual();
    t_quad();
    stop_test();
  end
endmodule
